// File: design/dhp_host_port.sv
// Host bus port: strobes, address latch, data lanes, sync pin, interrupt and DMA
// Operation
// - Bus width high: low byte only, upper eight lines released.
// - Bus width low: all sixteen data lines carry transfers.
// - Drive data only while read strobe and chip select are low.
// - Take write data only while write strobe and chip select are low.
// - Chip select low freezes conversion clocking; resumes when high.
// - Latch strobe high passes address; falling edge captures address and select.
// - Latch strobe low: address and select changes ignored, captured values used.
// - Five address lines select registers, FIFO and instruction store.
// - Sync direction low: sync is input, rising edge triggers sample hold.
// - Conversion starts on the third clock edge after sync rising edge.
// - Sync direction high: drive sync high during each conversion.
// - Reset makes the sync pin an input.
// - Interrupt low while any unmasked condition of eight pends.
// - Reading interrupt status clears pending conditions, releases interrupt.
// - DMA request rises when FIFO count equals programmed threshold.
// - DMA request drops once FIFO is empty.
// - Channel choice comes from instruction store, passed to analog side.
// - Eight instructions on upper four lines, or all five in byte mode.
module dhp_host_port (
	input  wire logic                       ref_clk_i,
	input  wire logic                       sys_rst_i,
	input  wire dhp_pkg::dhp_bus_t          bus_i,
	input  wire logic [dhp_pkg::DATA_W-1:0] data_i,
	output logic      [dhp_pkg::DATA_W-1:0] data_o,
	output logic      [1:0]                 data_oe_n_o,
	input  wire logic [dhp_pkg::DATA_W-1:0] rd_word_i,
	output logic      [dhp_pkg::ADDR_W-1:0] word_addr_o,
	output logic                            instr_sel_o,
	output logic      [2:0]                 instr_idx_o,
	output logic      [dhp_pkg::DATA_W-1:0] wr_word_o,
	output logic      [1:0]                 wr_lane_o,
	output logic                            wr_stb_o,
	output logic                            rd_stb_o,
	output logic                            conv_run_o,
	input  wire logic                       sync_dir_i,
	input  wire logic                       sync_i,
	output logic                            sync_o,
	output logic                            sync_oe_n_o,
	input  wire logic                       conv_busy_i,
	output logic                            conv_start_o,
	input  wire logic [dhp_pkg::NUM_INT-1:0] int_event_i,
	input  wire logic [dhp_pkg::NUM_INT-1:0] int_mask_i,
	input  wire logic [dhp_pkg::ADDR_W-1:0] int_stat_addr_i,
	output logic      [dhp_pkg::NUM_INT-1:0] int_stat_o,
	output logic                            int_n_o,
	input  wire logic [dhp_pkg::CNT_W-1:0]  fifo_cnt_i,
	input  wire logic [dhp_pkg::CNT_W-1:0]  dma_thresh_i,
	output logic                            dma_request_out_o
);
	import dhp_pkg::*;

	dhp_bus_t                s1_reg;
	dhp_bus_t                s2_reg;
	logic [DATA_W-1:0]       d1_reg;
	logic [DATA_W-1:0]       d2_reg;
	logic [2:0]              sy_reg;
	logic                    ale_q_reg;
	logic [ADDR_W-1:0]       lat_addr_reg;
	logic                    lat_cs_n_reg;
	logic [ADDR_W-1:0]       eff_addr;
	logic                    eff_cs_n;
	logic                    rd_act;
	logic                    wr_act;
	dhp_state_t              state_reg;
	dhp_state_t              state_next;
	logic [NUM_INT-1:0]      pend_reg;
	logic                    stat_rd;
	logic                    sync_rise;
	logic                    byte_mode;

	// Pin synchronisers
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s1_reg <= '{rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1, ale: 1'b1,
				bus_width_select: 1'b0, addr: '0};
			s2_reg <= '{rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1, ale: 1'b1,
				bus_width_select: 1'b0, addr: '0};
			d1_reg <= '0;
			d2_reg <= '0;
			sy_reg <= '0;
		end else begin
			s1_reg <= bus_i;
			s2_reg <= s1_reg;
			d1_reg <= data_i;
			d2_reg <= d1_reg;
			sy_reg <= {sy_reg[1:0], sync_i};
		end
	end

	// Address and select latch
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ale_q_reg    <= 1'b1;
			lat_addr_reg <= '0;
			lat_cs_n_reg <= 1'b1;
		end else begin
			ale_q_reg <= s2_reg.ale;
			if (s2_reg.ale) begin
				lat_addr_reg <= s2_reg.addr;
				lat_cs_n_reg <= s2_reg.cs_n;
			end
		end
	end

	always_comb begin
		byte_mode = s2_reg.bus_width_select;
		eff_addr = s2_reg.ale ? s2_reg.addr : lat_addr_reg;
		eff_cs_n = s2_reg.ale ? s2_reg.cs_n : lat_cs_n_reg;
		rd_act   = !eff_cs_n && !s2_reg.rd_n;
		wr_act   = !eff_cs_n && !s2_reg.wr_n;
	end

	// Access state
	always_comb begin
		state_next = DHP_IDLE;
		if (rd_act) begin
			state_next = DHP_READ;
		end else if (wr_act) begin
			state_next = DHP_WRITE;
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg <= DHP_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Address decode and strobes
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			word_addr_o <= '0;
			instr_sel_o <= 1'b0;
			instr_idx_o <= '0;
			wr_word_o   <= '0;
			wr_lane_o   <= '0;
			wr_stb_o    <= 1'b0;
			rd_stb_o    <= 1'b0;
			conv_run_o  <= 1'b1;
		end else begin
			conv_run_o <= eff_cs_n;
			if (byte_mode) begin
				word_addr_o <= {1'b0, eff_addr[ADDR_W-1:1]};
				instr_sel_o <= (eff_addr <= ADDR_W'(INSTR_MAX_8));
			end else begin
				word_addr_o <= eff_addr;
				instr_sel_o <= (eff_addr[ADDR_W-1:1] <= 4'(INSTR_MAX_16));
			end
			instr_idx_o <= eff_addr[3:1];
			rd_stb_o <= (state_reg != DHP_READ) && rd_act;
			wr_stb_o <= (state_reg == DHP_WRITE) && !wr_act;
			if (wr_act) begin
				if (byte_mode) begin
					wr_word_o <= {d2_reg[7:0], d2_reg[7:0]};
					wr_lane_o <= eff_addr[BYTE_SEL_BIT] ? 2'b10 : 2'b01;
				end else begin
					wr_word_o <= d2_reg;
					wr_lane_o <= 2'b11;
				end
			end
		end
	end

	// Read data lanes
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			data_o      <= '0;
			data_oe_n_o <= 2'b11;
		end else begin
			if (rd_act && byte_mode) begin
				data_o <= {8'h00, eff_addr[BYTE_SEL_BIT] ? rd_word_i[15:8] : rd_word_i[7:0]};
			end else if (rd_act) begin
				data_o <= rd_word_i;
			end else begin
				data_o <= '0;
			end
			data_oe_n_o[0] <= !rd_act;
			data_oe_n_o[1] <= !(rd_act && !byte_mode);
		end
	end

	// Sync pin
	always_comb begin
		sync_rise = sy_reg[1] && !sy_reg[2];
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sync_oe_n_o  <= 1'b1;
			sync_o       <= 1'b0;
			conv_start_o <= 1'b0;
		end else begin
			sync_oe_n_o  <= !sync_dir_i;
			sync_o       <= sync_dir_i && conv_busy_i;
			conv_start_o <= !sync_dir_i && sync_rise && eff_cs_n;
		end
	end

	// Interrupt
	always_comb begin
		stat_rd = rd_act && (state_reg != DHP_READ) && (eff_addr == int_stat_addr_i);
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pend_reg <= INT_STAT_RST;
		end else begin
			pend_reg <= (stat_rd ? '0 : pend_reg) | int_event_i;
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			int_stat_o <= INT_STAT_RST;
			int_n_o    <= 1'b1;
		end else begin
			int_stat_o <= pend_reg;
			int_n_o    <= !(|(pend_reg & ~int_mask_i)) || stat_rd;
		end
	end

	// DMA request
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			dma_request_out_o <= 1'b0;
		end else if (fifo_cnt_i == FIFO_CNT_RST) begin
			dma_request_out_o <= 1'b0;
		end else if (fifo_cnt_i == dma_thresh_i) begin
			dma_request_out_o <= 1'b1;
		end
	end

	chk_hi_lane_off: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		byte_mode |=> data_oe_n_o[1]) else $error("upper lane driven in byte mode");
	chk_full_lane: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(rd_act && !byte_mode) |=> !data_oe_n_o[1]) else $error("upper lane not driven");
	chk_drive_read: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!rd_act |=> data_oe_n_o == 2'b11) else $error("bus driven without read");
	chk_run_freeze: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!eff_cs_n |=> !conv_run_o) else $error("clocking not frozen");
	chk_latch_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(!s2_reg.ale && !ale_q_reg) |=> $stable(lat_addr_reg)) else $error("latch moved");
	chk_sync_start: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(sync_rise && !sync_dir_i && eff_cs_n) |=> conv_start_o) else $error("no start");
	chk_sync_in: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!sync_dir_i |=> sync_oe_n_o) else $error("sync driven as input");
	chk_int_low: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(|(pend_reg & ~int_mask_i) && !stat_rd) |=> !int_n_o) else $error("int not low");
	chk_stat_clear: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(stat_rd && int_event_i == '0) |=> pend_reg == '0) else $error("status not cleared");
	chk_dma_empty: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(fifo_cnt_i == FIFO_CNT_RST) |=> !dma_request_out_o) else $error("dma held on empty");

	// Data lanes and write capture
	chk_rd_lane_lo: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		rd_act |=> !data_oe_n_o[0])
		else $error("low lane not driven on read");
	chk_byte_hi_zero: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(rd_act && byte_mode) |=> data_o[15:8] == 8'h00)
		else $error("upper byte not zero in byte mode");
	chk_full_data: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(rd_act && !byte_mode) |=> data_o == $past(rd_word_i))
		else $error("full word read mismatch");
	chk_byte_low: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(rd_act && byte_mode && !eff_addr[0]) |=> data_o[7:0] == $past(rd_word_i[7:0]))
		else $error("low byte read mismatch");
	chk_byte_high: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(rd_act && byte_mode && eff_addr[0]) |=> data_o[7:0] == $past(rd_word_i[15:8]))
		else $error("high byte read mismatch");
	chk_wr_full: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(wr_act && !byte_mode) |=> (wr_word_o == $past(d2_reg) && wr_lane_o == 2'b11))
		else $error("full word write mismatch");
	chk_wr_lane_lo: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(wr_act && byte_mode && !eff_addr[0]) |=> wr_lane_o == 2'b01)
		else $error("low byte lane wrong");
	chk_wr_lane_hi: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(wr_act && byte_mode && eff_addr[0]) |=> wr_lane_o == 2'b10)
		else $error("high byte lane wrong");
	chk_wr_byte: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(wr_act && byte_mode) |=> wr_word_o == {2{$past(d2_reg[7:0])}})
		else $error("byte write data wrong");
	chk_wr_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!wr_act |=> $stable(wr_word_o))
		else $error("write data taken without strobe");
	chk_wr_pulse: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(state_reg == DHP_WRITE && !wr_act) |=> wr_stb_o)
		else $error("no write pulse at release");
	chk_wr_quiet: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(state_reg != DHP_WRITE) |=> !wr_stb_o)
		else $error("write pulse without write");
	chk_rd_pulse: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(rd_act && state_reg != DHP_READ) |=> rd_stb_o)
		else $error("no read pulse");
	chk_rd_once: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		rd_stb_o |=> !rd_stb_o)
		else $error("read pulse too long");

	// Clock freeze, address latch and address decode
	chk_run_resume: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		eff_cs_n |=> conv_run_o)
		else $error("clocking not resumed");
	chk_latch_addr: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		s2_reg.ale |=> lat_addr_reg == $past(s2_reg.addr))
		else $error("address not followed");
	chk_latch_cs: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		s2_reg.ale |=> lat_cs_n_reg == $past(s2_reg.cs_n))
		else $error("select not followed");
	chk_cs_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!s2_reg.ale |=> $stable(lat_cs_n_reg))
		else $error("latched select moved");
	chk_word_full: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!byte_mode |=> word_addr_o == $past(eff_addr))
		else $error("word address wrong");
	chk_word_byte: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		byte_mode |=> word_addr_o == {1'b0, $past(eff_addr[ADDR_W-1:1])})
		else $error("byte mode word address wrong");
	chk_instr_idx: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(rd_act || wr_act) |=> instr_idx_o == $past(eff_addr[3:1]))
		else $error("instruction index wrong");
	chk_instr_sel: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(rd_act || wr_act) |=> instr_sel_o == !$past(eff_addr[ADDR_W-1]))
		else $error("instruction area decode wrong");

	// Sync pin, interrupt and DMA
	chk_sync_out: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		sync_dir_i |=> (!sync_oe_n_o && sync_o == $past(conv_busy_i)))
		else $error("sync output wrong");
	chk_sync_gate: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(!sync_dir_i && !sync_rise) |=> !conv_start_o)
		else $error("start without sync edge");
	chk_sync_frozen: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!eff_cs_n |=> !conv_start_o)
		else $error("start while frozen");
	chk_int_idle: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		!(|(pend_reg & ~int_mask_i)) |=> int_n_o)
		else $error("int low without cause");
	chk_stat_release: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		stat_rd |=> int_n_o)
		else $error("int not released on status read");
	chk_event_wins: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(stat_rd && int_event_i != '0) |=> pend_reg == $past(int_event_i))
		else $error("event lost on status read");
	chk_dma_rise: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(fifo_cnt_i != FIFO_CNT_RST && fifo_cnt_i == dma_thresh_i) |=> dma_request_out_o)
		else $error("dma not raised on threshold");
	chk_dma_keep: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(fifo_cnt_i != FIFO_CNT_RST && fifo_cnt_i != dma_thresh_i)
		|=> dma_request_out_o == $past(dma_request_out_o))
		else $error("dma moved without cause");

	cov_read: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) rd_stb_o);
	cov_write: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) wr_stb_o);
	cov_dma: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) $rose(dma_request_out_o));
	cov_int: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) $fell(int_n_o));
	cov_sync: cover property (@(posedge ref_clk_i) disable iff (sys_rst_i) conv_start_o);
endmodule

// File: design/dhp_pkg.sv
// Package for the data acquisition host bus port
package dhp_pkg;
	localparam int ADDR_W     = 5;
	localparam int DATA_W     = 16;
	localparam int CNT_W      = 6;
	localparam int NUM_INT    = 8;
	localparam int BYTE_SEL_BIT = 0;
	localparam int INSTR_MAX_16 = 7;
	localparam int INSTR_MAX_8  = 15;
	localparam logic [CNT_W-1:0] FIFO_CNT_RST = 6'h00;
	localparam logic [7:0] INT_STAT_RST = 8'h00;

	typedef struct packed {
		logic                rd_n;
		logic                wr_n;
		logic                cs_n;
		logic                ale;
		logic                bus_width_select;
		logic [ADDR_W-1:0]   addr;
	} dhp_bus_t;

	typedef enum logic [1:0] {
		DHP_IDLE = 2'b00,
		DHP_READ = 2'b01,
		DHP_WRITE = 2'b10
	} dhp_state_t;
endpackage

// File: verification/dhp_host_model.sv
// Host processor model for the parallel bus port
module dhp_host_model (
	input  wire logic                       ref_clk_i,
	input  wire logic [dhp_pkg::DATA_W-1:0] dq_i,
	output dhp_pkg::dhp_bus_t               bus_o,
	output logic      [dhp_pkg::DATA_W-1:0] data_o
);
	timeunit 1ns;
	timeprecision 100ps;
	import dhp_pkg::*;
	bit drv = 1'b0;
	initial bus_o = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 5'h00};
	initial data_o = 16'h3C5A;
	// Released lanes toggle
	always @(posedge ref_clk_i) if (!drv) data_o <= ~data_o;
	task automatic access(input bit wr, byte_mode, mux, input logic [4:0] a,
		input logic [15:0] d, output logic [15:0] q);
		@(posedge ref_clk_i) #1;
		bus_o.bus_width_select = byte_mode;
		bus_o.addr = a;
		bus_o.cs_n = 1'b0;
		if (mux) begin
			repeat (3) @(posedge ref_clk_i);
			#1 bus_o.ale = 1'b0;
			repeat (3) @(posedge ref_clk_i);
			#1 bus_o.addr = ~a;
			bus_o.cs_n = 1'b1;
		end
		drv = wr;
		if (wr) data_o = d;
		bus_o.rd_n = wr;
		bus_o.wr_n = !wr;
		repeat (5) @(posedge ref_clk_i);
		#1 q = dq_i;
		bus_o.rd_n = 1'b1;
		bus_o.wr_n = 1'b1;
		bus_o.cs_n = 1'b1;
		bus_o.ale = 1'b1;
		repeat (5) @(posedge ref_clk_i);
		#1 drv = 1'b0;
	endtask
endmodule

// File: verification/daq_host_bus_port_tb_top.sv
// Self-checking bench for the host bus port
module daq_host_bus_port_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import dhp_pkg::*;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic sync_dir, sync_in, sync_w, busy, ws, rs, run, so, soe, cst, in_n, dma, isel, wseen;
	int nrd = 0;
	logic [7:0] ev, msk, st;
	logic [5:0] cnt, thr;
	logic [15:0] dq, hd, dd, ww, rq, cw;
	logic [4:0] wa;
	logic [2:0] idx;
	logic [1:0] oe, wl, cl;
	dhp_bus_t bus;
	int err_total = 0;
	int checks = 0;
	int nst = 0;
	always #20 ref_clk_i = ~ref_clk_i;
	assign dq = {oe[1] ? hd[15:8] : dd[15:8], oe[0] ? hd[7:0] : dd[7:0]};
	assign sync_w = soe ? sync_in : so;
	dhp_host_port dut (.ref_clk_i, .sys_rst_i, .bus_i(bus), .data_i(dq), .data_o(dd),
		.data_oe_n_o(oe), .rd_word_i({wa, 3'h5, ~wa, 3'h2}), .word_addr_o(wa),
		.instr_sel_o(isel), .instr_idx_o(idx), .wr_word_o(ww), .wr_lane_o(wl),
		.wr_stb_o(ws), .rd_stb_o(rs), .conv_run_o(run), .sync_dir_i(sync_dir),
		.sync_i(sync_w), .sync_o(so), .sync_oe_n_o(soe), .conv_busy_i(busy),
		.conv_start_o(cst), .int_event_i(ev), .int_mask_i(msk), .int_stat_addr_i(5'h1A),
		.int_stat_o(st), .int_n_o(in_n), .fifo_cnt_i(cnt), .dma_thresh_i(thr),
		.dma_request_out_o(dma));
	dhp_host_model host (.ref_clk_i, .dq_i(dq), .bus_o(bus), .data_o(hd));
	always @(posedge ref_clk_i) begin
		if (ws === 1'b1) {wseen, cw, cl} <= {1'b1, ww, wl};
		if (cst === 1'b1) nst <= nst + 1;
		if (rs === 1'b1) nrd <= nrd + 1;
	end
	task automatic chk(input string n, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	function automatic int word_of(int w);
		return (w << 11) | 32'h500 | ((w ^ 31) << 3) | 2;
	endfunction
	task automatic op(input bit wr, byte_mode, mux, input logic [4:0] a, input logic [15:0] d);
		int w;
		int e;
		logic [15:0] m;
		w = byte_mode ? a >> 1 : a;
		e = byte_mode ? (word_of(w) >> (a[0] ? 8 : 0)) & 255 : word_of(w);
		m = byte_mode ? (a[0] ? 16'hFF00 : 16'h00FF) : 16'hFFFF;
		wseen = 1'b0;
		nrd = 0;
		fork
			host.access(wr, byte_mode, mux, a, d, rq);
			begin
				repeat (mux ? 10 : 4) @(posedge ref_clk_i);
				#2 chk("run", 0, run);
				chk("word_addr", w, wa);
				chk("instr_sel", !a[4], isel);
				chk("instr_idx", a[3:1], idx);
				if (!wr) chk("oe_read", byte_mode ? 2 : 0, oe);
			end
		join
		#2 chk("oe_idle", 3, oe);
		chk("wr_seen", wr, wseen);
		chk("rd_pulse", !wr, nrd);
		chk("run_back", 1, run);
		if (wr) chk("wr_lane", byte_mode ? (a[0] ? 2 : 1) : 3, cl);
		if (wr) chk("wr_word", (byte_mode ? {2{d[7:0]}} : d) & m, cw & m);
		if (!wr) chk("rd_data", e, byte_mode ? rq & 16'h00FF : rq);
	endtask
	initial begin
		#200000;
		err_total++;
		final_report();
	end
	initial begin
		{sync_dir, sync_in, busy, ev, msk, cnt, thr} = '0;
		void'($urandom(65));
		tick(16);
		sys_rst_i = 1'b0;
		chk("oe_rst", 3, oe);
		chk("sync_rst", 1, soe);
		tick(3);
		for (int i = 0; i < 30; i++)
			op(1'($urandom), 1'($urandom), i % 3 == 0, 5'($urandom), 16'($urandom));
		msk = 8'h01;
		ev = 8'h01;
		tick(1);
		ev = 8'h00;
		tick(4);
		chk("int_masked", 1, in_n);
		ev = 8'h80;
		tick(1);
		ev = 8'h00;
		tick(4);
		chk("int_low", 0, in_n);
		chk("int_stat", 8'h80, st & 8'h80);
		op(1'b0, 1'b0, 1'b0, 5'h1A, 16'h0000);
		chk("int_clear", 1, in_n);
		chk("stat_clear", 0, st);
		thr = 6'd1 + 6'($urandom % 30);
		cnt = thr - 6'd1;
		tick(4);
		chk("dma_below", 0, dma);
		cnt = thr;
		tick(4);
		chk("dma_equal", 1, dma);
		cnt = thr + 6'd1;
		tick(4);
		chk("dma_hold", 1, dma);
		cnt = 6'd0;
		tick(4);
		chk("dma_empty", 0, dma);
		nst = 0;
		sync_in = 1'b1;
		tick(8);
		chk("sync_start", 1, nst);
		sync_in = 1'b0;
		sync_dir = 1'b1;
		busy = 1'b1;
		tick(4);
		chk("sync_drive", 0, soe);
		chk("sync_high", 1, so);
		busy = 1'b0;
		tick(4);
		chk("sync_low", 0, so);
		final_report();
	end
endmodule
